/* File: rdr_pkg.sv */
// Purpose: shared constants for the re-driver configuration register bank
// Assumes: byte-wide registers reached through a two-wire serial slave port
// Notes: lane equalizer settings live in the rdr_lane_eq_mem module
// Behaviour
// - trim bits 4:3 scale every pre-emphasis: 00 less, 01 nominal default, 10 more
// - trim also acts in TMDS mode; with emphasis off it scales swing instead
// - bit 2 picks TMDS swing, low by default or high
// - bits 1:0 pick TMDS emphasis: none default, low, high, 11 reserved
// - hot-plug test bit clear: source hot-plug output follows sink hot-plug input
// - hot-plug test bit set: sink input taken high, output high, link enabled per squelch
// - bit 1 sets adapter detect polarity: clear means high is detected
// - adapter test bit clear: source detect output follows sink input with polarity
// - adapter test bit set: sink input ignored, output shows TMDS mode with polarity
// - writing one to reset bit 7 returns every register to its default
// - writing zero to reset bits does nothing; reset bits always read zero
// - writing one to reset bit 6 clears only the lane equalizer settings
// - config address is upper[3:0], middle and lower registers forming 20 bits
// - data port writes store to and reads return the addressed config location
// - identity bits 7:1 are read-only and return a fixed 7-bit code
// - identity bit 0 reads the inverse of the last write, zero after reset
// - offsets 22h to 27h are read-only reserved test registers ignoring writes
// - each lane holds four 3-bit settings, two per byte at 6:4 and 2:0
package rdr_pkg;
	// register offsets
	localparam logic [7:0] OFS_COND = 8'h15;
	localparam logic [7:0] OFS_DETECT = 8'h17;
	localparam logic [7:0] OFS_FTEST_LO = 8'h18;
	localparam logic [7:0] OFS_FTEST_HI = 8'h1A;
	localparam logic [7:0] OFS_RESET = 8'h1B;
	localparam logic [7:0] OFS_ADDR_UP = 8'h1C;
	localparam logic [7:0] OFS_ADDR_MID = 8'h1D;
	localparam logic [7:0] OFS_ADDR_LOW = 8'h1E;
	localparam logic [7:0] OFS_DATA = 8'h1F;
	localparam logic [7:0] OFS_IDENT = 8'h20;
	localparam logic [7:0] OFS_FTEST_B = 8'h21;
	localparam logic [7:0] OFS_RO_LO = 8'h22;
	localparam logic [7:0] OFS_RO_HI = 8'h27;
	// field positions
	localparam int TRIM_HI = 4;
	localparam int TRIM_LO = 3;
	localparam int SWING_BIT = 2;
	localparam int EMPH_HI = 1;
	localparam int HP_TEST_BIT = 3;
	localparam int CAD_POL_BIT = 1;
	localparam int CAD_TEST_BIT = 0;
	localparam int SOFT_RESET_BIT = 7;
	localparam int EQ_RESET_BIT = 6;
	// values after reset
	localparam logic [4:0] COND_RESET = 5'h08;
	localparam logic [1:0] TRIM_NOMINAL = 2'h1;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] EQ_RESET = 8'h00;
	localparam logic [7:0] EQ_MASK = 8'h77;
	localparam logic [7:0] RO_TEST_VALUE = 8'h00;
	// config space window holding the lane equalizer settings
	localparam logic [7:0] CFG_LANE_FIRST = 8'h03;
	localparam logic [7:0] CFG_LANE_LAST = 8'h06;
	localparam logic [11:0] CFG_PAGE_L01 = 12'h001;
	localparam logic [11:0] CFG_PAGE_L23 = 12'h002;
	localparam int EQ_ENTRIES = 8;
	localparam int EQ_IDX_W = 3;
	localparam int PIN_SYNC_W = 4;
	localparam logic [3:0] BIT_COUNT_BYTE = 4'h8;
	typedef enum logic [3:0] {
		RDR_IDLE = 4'h0,
		RDR_ADDR = 4'h1,
		RDR_ADDR_ACK = 4'h3,
		RDR_REG = 4'h2,
		RDR_REG_ACK = 4'h6,
		RDR_WDATA = 4'h7,
		RDR_WDATA_ACK = 4'h5,
		RDR_RDATA = 4'h4,
		RDR_RDATA_ACK = 4'hC
	} rdr_state_t;
endpackage

/* File: rdr_sync2.sv */
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk_sys
// Notes: only the second stage leaves this module
`timescale 1ns/1ps
module rdr_sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// pins and synchronised copy
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} rdr_sync_t;
	rdr_sync_t s_r;
	rdr_sync_t s_nxt;
	always_comb begin
		s_nxt.stage1 = pin_in;
		s_nxt.stage2 = s_r.stage1;
	end
	// shifts through reset too: the stages settle at the line levels before release,
	// so idle-high serial lines give the edge detectors no false edge afterwards
	always_ff @(posedge clk_sys) begin
		s_r <= s_nxt;
	end
	assign sync_out = s_r.stage2;
endmodule

/* File: rdr_lane_eq_mem.sv */
// Purpose: storage for the per-lane equalizer settings
// Assumes: one write port, one registered read port
// Notes: full contents also leave in parallel to steer the equalizers
`timescale 1ns/1ps
module rdr_lane_eq_mem (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// access port
	input wire logic clear,
	input wire logic we,
	input wire logic [rdr_pkg::EQ_IDX_W-1:0] idx,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	// parallel contents, entry lane + 4 * level pair
	output logic [rdr_pkg::EQ_ENTRIES-1:0][7:0] entries
);
	typedef struct packed {
		logic [rdr_pkg::EQ_ENTRIES-1:0][7:0] ent;
		logic [7:0] rdata;
	} rdr_mem_t;
	rdr_mem_t s_r;
	rdr_mem_t s_nxt;
	always_comb begin
		s_nxt = s_r;
		if (clear) begin
			for (int i = 0; i < rdr_pkg::EQ_ENTRIES; i++) begin
				s_nxt.ent[i] = rdr_pkg::EQ_RESET;
			end
		end else if (we) begin
			// only the two 3-bit fields exist
			s_nxt.ent[idx] = wdata & rdr_pkg::EQ_MASK;
		end
		s_nxt.rdata = s_r.ent[idx];
	end
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign rdata = s_r.rdata;
	assign entries = s_r.ent;
endmodule

/* File: rdr_register_bank.sv */
// Purpose: serial-slave register bank for the re-driver output and detect controls
// Assumes: scl and sda arrive as pins; sda is open drain, pulled up outside
// Notes: the register pointer advances per data byte; config address never does
`timescale 1ns/1ps
module rdr_register_bank #(
	// arbitrary values, not tied to any real part
	parameter logic [6:0] SLAVE_ADDR = 7'h2C,
	parameter logic [6:0] PART_IDENTITY = 7'h2A
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// serial port
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// sideband pins and link status
	input wire logic sink_hotplug_in,
	input wire logic sink_adapter_detect_in,
	input wire logic squelch_open,
	input wire logic pre_emphasis_active,
	output logic source_hotplug_out,
	output logic source_adapter_detect_out,
	output logic main_link_enable,
	// output conditioning controls
	output logic [1:0] emphasis_trim,
	output logic [1:0] swing_trim,
	output logic tmds_swing_select,
	output logic [1:0] tmds_emphasis_select,
	// lane equalizer settings, 3 bits per lane and level
	output logic [rdr_pkg::EQ_ENTRIES-1:0][7:0] lane_level_equalizer_setting
);
	typedef struct packed {
		rdr_pkg::rdr_state_t st;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic [7:0] tx;
		logic rw;
		logic nack;
		logic [7:0] ptr;
		logic drive;
		logic scl_q;
		logic sda_q;
		logic [4:0] cond;
		logic hp_test;
		logic cad_pol;
		logic cad_test;
		logic [3:0][7:0] ftest;
		logic [3:0] addr_up;
		logic [7:0] addr_mid;
		logic [7:0] addr_low;
		logic inv_store;
		logic hp_out;
		logic cad_out;
		logic link_en;
		logic [1:0] swing_trim;
	} rdr_bank_t;

	rdr_bank_t s_r;
	rdr_bank_t s_nxt;
	logic [rdr_pkg::PIN_SYNC_W-1:0] pins_sync;
	logic scl_s;
	logic sda_s;
	logic hp_s;
	logic cad_s;
	logic mem_clear;
	logic mem_we;
	logic [7:0] mem_wdata;
	logic [7:0] mem_rdata;
	logic [3:0] cfg_dec;
	logic [7:0] rd_byte;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic hp_eff;
	logic cad_raw;

	rdr_sync2 #(
		.WIDTH(rdr_pkg::PIN_SYNC_W)
	) u_sync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.pin_in({scl_in, sda_in, sink_hotplug_in, sink_adapter_detect_in}),
		.sync_out(pins_sync)
	);
	assign scl_s = pins_sync[3];
	assign sda_s = pins_sync[2];
	assign hp_s = pins_sync[1];
	assign cad_s = pins_sync[0];

	// slot of the factory test storage; bit 2 flags a hit
	function automatic logic [2:0] ftest_slot(input logic [7:0] ofs);
		if (ofs >= rdr_pkg::OFS_FTEST_LO && ofs <= rdr_pkg::OFS_FTEST_HI) begin
			ftest_slot = {1'b1, 2'(ofs - rdr_pkg::OFS_FTEST_LO)};
		end else if (ofs == rdr_pkg::OFS_FTEST_B) begin
			ftest_slot = 3'h7;
		end else begin
			ftest_slot = 3'h0;
		end
	endfunction

	// config address to equalizer entry; bit 3 flags a hit
	function automatic logic [3:0] cfg_index(input logic [19:0] a);
		logic [7:0] lane_ofs;
		lane_ofs = a[7:0] - rdr_pkg::CFG_LANE_FIRST;
		if (a[7:0] >= rdr_pkg::CFG_LANE_FIRST && a[7:0] <= rdr_pkg::CFG_LANE_LAST &&
			(a[19:8] == rdr_pkg::CFG_PAGE_L01 || a[19:8] == rdr_pkg::CFG_PAGE_L23)) begin
			cfg_index = {1'b1, a[19:8] == rdr_pkg::CFG_PAGE_L23, lane_ofs[1:0]};
		end else begin
			cfg_index = 4'h0;
		end
	endfunction

	assign cfg_dec = cfg_index({s_r.addr_up, s_r.addr_mid, s_r.addr_low});

	rdr_lane_eq_mem u_eq (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.clear(mem_clear),
		.we(mem_we),
		.idx(cfg_dec[2:0]),
		.wdata(mem_wdata),
		.rdata(mem_rdata),
		.entries(lane_level_equalizer_setting)
	);

	// read multiplexer for the register pointer
	always_comb begin
		logic [2:0] slot;
		slot = ftest_slot(s_r.ptr);
		rd_byte = rdr_pkg::BYTE_ZERO;
		if (slot[2]) begin
			rd_byte = s_r.ftest[slot[1:0]];
		end else begin
			case (s_r.ptr)
				rdr_pkg::OFS_COND: rd_byte = {3'h0, s_r.cond};
				rdr_pkg::OFS_DETECT: rd_byte = {4'h0, s_r.hp_test, 1'b0, s_r.cad_pol, s_r.cad_test};
				rdr_pkg::OFS_RESET: rd_byte = rdr_pkg::BYTE_ZERO;
				rdr_pkg::OFS_ADDR_UP: rd_byte = {4'h0, s_r.addr_up};
				rdr_pkg::OFS_ADDR_MID: rd_byte = s_r.addr_mid;
				rdr_pkg::OFS_ADDR_LOW: rd_byte = s_r.addr_low;
				// unmapped config locations read zero
				rdr_pkg::OFS_DATA: rd_byte = cfg_dec[3] ? mem_rdata : rdr_pkg::BYTE_ZERO;
				rdr_pkg::OFS_IDENT: rd_byte = {PART_IDENTITY, ~s_r.inv_store};
				default: begin
					if (s_r.ptr >= rdr_pkg::OFS_RO_LO && s_r.ptr <= rdr_pkg::OFS_RO_HI) begin
						rd_byte = rdr_pkg::RO_TEST_VALUE;
					end
				end
			endcase
		end
	end

	assign scl_rise = scl_s && !s_r.scl_q;
	assign scl_fall = !scl_s && s_r.scl_q;
	assign start_cond = scl_s && s_r.scl_q && s_r.sda_q && !sda_s;
	assign stop_cond = scl_s && s_r.scl_q && !s_r.sda_q && sda_s;
	assign hp_eff = s_r.hp_test ? 1'b1 : hp_s;
	assign cad_raw = s_r.cad_test ? 1'b1 : cad_s;

	always_comb begin
		logic [2:0] wslot;
		logic wr_byte;
		s_nxt = s_r;
		mem_clear = 1'b0;
		mem_we = 1'b0;
		mem_wdata = s_r.shreg;
		wr_byte = 1'b0;
		wslot = ftest_slot(s_r.ptr);
		s_nxt.scl_q = scl_s;
		s_nxt.sda_q = sda_s;
		if (scl_rise) begin
			s_nxt.shreg = {s_r.shreg[6:0], sda_s};
			s_nxt.bitcnt = s_r.bitcnt + 4'h1;
		end
		case (s_r.st)
			rdr_pkg::RDR_IDLE: begin
				s_nxt.drive = 1'b0;
			end
			rdr_pkg::RDR_ADDR: begin
				if (scl_fall && s_r.bitcnt == rdr_pkg::BIT_COUNT_BYTE) begin
					if (s_r.shreg[7:1] == SLAVE_ADDR) begin
						s_nxt.drive = 1'b1;
						s_nxt.rw = s_r.shreg[0];
						s_nxt.st = rdr_pkg::RDR_ADDR_ACK;
					end else begin
						s_nxt.st = rdr_pkg::RDR_IDLE;
					end
				end
			end
			rdr_pkg::RDR_ADDR_ACK: begin
				if (scl_fall) begin
					s_nxt.bitcnt = 4'h0;
					if (s_r.rw) begin
						s_nxt.tx = rd_byte;
						s_nxt.drive = ~rd_byte[7];
						s_nxt.st = rdr_pkg::RDR_RDATA;
					end else begin
						s_nxt.drive = 1'b0;
						s_nxt.st = rdr_pkg::RDR_REG;
					end
				end
			end
			rdr_pkg::RDR_REG: begin
				if (scl_fall && s_r.bitcnt == rdr_pkg::BIT_COUNT_BYTE) begin
					s_nxt.ptr = s_r.shreg;
					s_nxt.drive = 1'b1;
					s_nxt.st = rdr_pkg::RDR_REG_ACK;
				end
			end
			rdr_pkg::RDR_REG_ACK, rdr_pkg::RDR_WDATA_ACK: begin
				if (scl_fall) begin
					s_nxt.drive = 1'b0;
					s_nxt.bitcnt = 4'h0;
					s_nxt.st = rdr_pkg::RDR_WDATA;
				end
			end
			rdr_pkg::RDR_WDATA: begin
				if (scl_fall && s_r.bitcnt == rdr_pkg::BIT_COUNT_BYTE) begin
					wr_byte = 1'b1;
					s_nxt.ptr = s_r.ptr + 8'h01;
					s_nxt.drive = 1'b1;
					s_nxt.st = rdr_pkg::RDR_WDATA_ACK;
				end
			end
			rdr_pkg::RDR_RDATA: begin
				if (scl_fall) begin
					if (s_r.bitcnt == rdr_pkg::BIT_COUNT_BYTE) begin
						s_nxt.drive = 1'b0;
						s_nxt.ptr = s_r.ptr + 8'h01;
						s_nxt.st = rdr_pkg::RDR_RDATA_ACK;
					end else begin
						s_nxt.tx = {s_r.tx[6:0], 1'b0};
						s_nxt.drive = ~s_r.tx[6];
					end
				end
			end
			rdr_pkg::RDR_RDATA_ACK: begin
				if (scl_rise) begin
					s_nxt.nack = sda_s;
				end
				if (scl_fall) begin
					s_nxt.bitcnt = 4'h0;
					if (s_r.nack) begin
						s_nxt.st = rdr_pkg::RDR_IDLE;
					end else begin
						s_nxt.tx = rd_byte;
						s_nxt.drive = ~rd_byte[7];
						s_nxt.st = rdr_pkg::RDR_RDATA;
					end
				end
			end
			default: begin
				s_nxt.st = rdr_pkg::RDR_IDLE;
				s_nxt.drive = 1'b0;
			end
		endcase
		if (start_cond) begin
			s_nxt.st = rdr_pkg::RDR_ADDR;
			s_nxt.bitcnt = 4'h0;
			s_nxt.drive = 1'b0;
		end else if (stop_cond) begin
			s_nxt.st = rdr_pkg::RDR_IDLE;
			s_nxt.drive = 1'b0;
		end
		// register write at the end of a data byte
		if (wr_byte) begin
			if (wslot[2]) begin
				// factory test bytes keep whatever is written
				s_nxt.ftest[wslot[1:0]] = s_r.shreg;
			end
			case (s_r.ptr)
				rdr_pkg::OFS_COND: s_nxt.cond = s_r.shreg[4:0];
				rdr_pkg::OFS_DETECT: begin
					s_nxt.hp_test = s_r.shreg[rdr_pkg::HP_TEST_BIT];
					s_nxt.cad_pol = s_r.shreg[rdr_pkg::CAD_POL_BIT];
					s_nxt.cad_test = s_r.shreg[rdr_pkg::CAD_TEST_BIT];
				end
				rdr_pkg::OFS_ADDR_UP: s_nxt.addr_up = s_r.shreg[3:0];
				rdr_pkg::OFS_ADDR_MID: s_nxt.addr_mid = s_r.shreg;
				rdr_pkg::OFS_ADDR_LOW: s_nxt.addr_low = s_r.shreg;
				rdr_pkg::OFS_DATA: mem_we = cfg_dec[3];
				rdr_pkg::OFS_IDENT: s_nxt.inv_store = s_r.shreg[0];
				rdr_pkg::OFS_RESET: begin
					// zero bits fall through untouched
					if (s_r.shreg[rdr_pkg::SOFT_RESET_BIT]) begin
						s_nxt.cond = rdr_pkg::COND_RESET;
						s_nxt.hp_test = 1'b0;
						s_nxt.cad_pol = 1'b0;
						s_nxt.cad_test = 1'b0;
						s_nxt.ftest = '0;
						s_nxt.addr_up = 4'h0;
						s_nxt.addr_mid = rdr_pkg::BYTE_ZERO;
						s_nxt.addr_low = rdr_pkg::BYTE_ZERO;
						s_nxt.inv_store = 1'b1;
					end
					mem_clear = s_r.shreg[rdr_pkg::SOFT_RESET_BIT] ||
						s_r.shreg[rdr_pkg::EQ_RESET_BIT];
				end
				default: begin
					// read-only and unmapped offsets drop the byte
					mem_we = 1'b0;
				end
			endcase
		end
		// sideband outputs, registered to avoid glitches on the pins
		s_nxt.hp_out = hp_eff;
		s_nxt.link_en = hp_eff && squelch_open;
		s_nxt.cad_out = cad_raw ^ s_r.cad_pol;
		// trim moves the swing only while emphasis is off
		s_nxt.swing_trim = pre_emphasis_active ? rdr_pkg::TRIM_NOMINAL :
			s_r.cond[rdr_pkg::TRIM_HI:rdr_pkg::TRIM_LO];
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			s_r <= '0;
			s_r.st <= rdr_pkg::RDR_IDLE;
			s_r.scl_q <= 1'b1;
			s_r.sda_q <= 1'b1;
			s_r.cond <= rdr_pkg::COND_RESET;
			s_r.inv_store <= 1'b1;
			s_r.swing_trim <= rdr_pkg::TRIM_NOMINAL;
		end else begin
			s_r <= s_nxt;
		end
	end

	// open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe = s_r.drive;
	assign source_hotplug_out = s_r.hp_out;
	assign source_adapter_detect_out = s_r.cad_out;
	assign main_link_enable = s_r.link_en;
	// trim reaches main link and TMDS emphasis alike
	assign emphasis_trim = s_r.cond[rdr_pkg::TRIM_HI:rdr_pkg::TRIM_LO];
	assign swing_trim = s_r.swing_trim;
	assign tmds_swing_select = s_r.cond[rdr_pkg::SWING_BIT];
	assign tmds_emphasis_select = s_r.cond[rdr_pkg::EMPH_HI:0];
endmodule

/* File: rdr_bank_props.sv */
// Purpose: concurrent checks on the register bank pins
// Assumes: sees only the top module ports, one clock domain
// Notes: bound into every rdr_register_bank instance
`timescale 1ns/1ps
module rdr_bank_props (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// serial port
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// sideband pins and link status
	input wire logic sink_hotplug_in,
	input wire logic sink_adapter_detect_in,
	input wire logic squelch_open,
	input wire logic pre_emphasis_active,
	input wire logic source_hotplug_out,
	input wire logic source_adapter_detect_out,
	input wire logic main_link_enable,
	// output conditioning controls
	input wire logic [1:0] emphasis_trim,
	input wire logic [1:0] swing_trim,
	input wire logic tmds_swing_select,
	input wire logic [1:0] tmds_emphasis_select,
	input wire logic [rdr_pkg::EQ_ENTRIES-1:0][7:0] lane_level_equalizer_setting
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	// six high samples leave no synced clock fall, so no register update
	sequence s_scl_quiet;
		scl_in [*6];
	endsequence
	sequence s_trim_idle;
		!pre_emphasis_active ##1 $stable(emphasis_trim);
	endsequence
	a_boost_emph_on: assert property (pre_emphasis_active |=> swing_trim == 2'b01)
		else $error("swing trim not nominal while emphasis on");
	a_boost_to_swing: assert property (s_trim_idle |-> swing_trim == emphasis_trim)
		else $error("swing trim does not follow boost field");
	a_reset_defaults: assert property ($rose(reset_n) |->
		emphasis_trim == 2'b01 && !tmds_swing_select && tmds_emphasis_select == 2'b00)
		else $error("conditioning outputs not at defaults after reset");
	a_hotplug_high: assert property (sink_hotplug_in [*4] |-> source_hotplug_out)
		else $error("source hot-plug low while sink hot-plug high");
	a_link_squelch: assert property (main_link_enable |-> $past(squelch_open))
		else $error("link enabled without squelch open");
	a_link_hotplug: assert property (main_link_enable |-> source_hotplug_out)
		else $error("link enabled while source hot-plug low");
	a_eq_field_mask: assert property (
		(lane_level_equalizer_setting & {rdr_pkg::EQ_ENTRIES{8'h88}}) == '0)
		else $error("equalizer setting uses bit 7 or bit 3");
	a_regs_hold_idle: assert property (s_scl_quiet |->
		$stable(tmds_emphasis_select) && $stable(tmds_swing_select) && $stable(emphasis_trim)
		&& $stable(lane_level_equalizer_setting))
		else $error("control register changed without a bus access");
endmodule
bind rdr_register_bank rdr_bank_props u_rdr_bank_props (.clk_sys, .reset_n, .scl_in,
	.sda_in, .sda_out, .sda_oe, .sink_hotplug_in, .sink_adapter_detect_in, .squelch_open,
	.pre_emphasis_active, .source_hotplug_out, .source_adapter_detect_out, .main_link_enable,
	.emphasis_trim, .swing_trim, .tmds_swing_select, .tmds_emphasis_select,
	.lane_level_equalizer_setting);

/* File: rdr_host_model.sv */
// Purpose: two-wire bus host that reads and writes the register bank
// Assumes: data line pulled up outside, both parties only pull low
// Notes: slow even timing so the device synchronisers see every edge
`timescale 1ns/1ps
module rdr_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h2C
) (
	// clock
	input wire logic clk_sys,
	// bus lines
	output logic scl_drv,
	output logic sda_pull,
	input wire logic sda_line
);
	// quarter bit period; keeps each clock phase at twice the device minimum
	localparam int Q = 4;
	int nacks = 0;
	initial begin
		scl_drv = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic wait_q();
		repeat (Q) @(posedge clk_sys);
	endtask
	// data moves only while the clock line is low
	task automatic bit_io(input logic b, output logic got);
		scl_drv <= 1'b0;
		wait_q();
		sda_pull <= ~b;
		wait_q();
		scl_drv <= 1'b1;
		wait_q();
		got = sda_line;
		wait_q();
	endtask
	task automatic start_c();
		logic g;
		bit_io(1'b1, g);
		sda_pull <= 1'b1;
		wait_q();
	endtask
	task automatic stop_c();
		logic g;
		bit_io(1'b0, g);
		sda_pull <= 1'b0;
		wait_q();
	endtask
	// last byte of a read is answered with a host not-acknowledge
	task automatic byte_io(input logic [7:0] tx, input logic rd_last, output logic [7:0] rx);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], g);
			rx[i] = g;
		end
		bit_io(1'b1, g);
		if (!rd_last) begin
			nacks += int'(g);
		end
	endtask
	task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
		logic [7:0] d;
		start_c();
		byte_io({DEV_ADDR, 1'b0}, 1'b0, d);
		byte_io(ptr, 1'b0, d);
		byte_io(data, 1'b0, d);
		stop_c();
	endtask
	task automatic rd(input logic [7:0] ptr, output logic [7:0] data);
		logic [7:0] d;
		start_c();
		byte_io({DEV_ADDR, 1'b0}, 1'b0, d);
		byte_io(ptr, 1'b0, d);
		start_c();
		byte_io({DEV_ADDR, 1'b1}, 1'b0, d);
		byte_io(8'hFF, 1'b1, data);
		stop_c();
	endtask
endmodule

/* File: tb_redriver_i2c_register_bank.sv */
// Purpose: register and pin level test of the re-driver register bank
// Assumes: host model drives the serial lines, bench drives sideband pins
// Notes: factory test offsets are never written
`timescale 1ns/1ps
module tb_redriver_i2c_register_bank;
	// arbitrary values, not tied to any real part
	localparam logic [6:0] DEV = 7'h3A;
	localparam logic [6:0] PART_ID = 7'h35;
	logic clk_sys, reset_n, scl_in, sda_in, sda_out, sda_oe, sda_pull;
	logic sink_hotplug_in, sink_adapter_detect_in, squelch_open, pre_emphasis_active;
	logic source_hotplug_out, source_adapter_detect_out, main_link_enable, tmds_swing_select;
	logic [1:0] emphasis_trim, swing_trim, tmds_emphasis_select;
	logic [rdr_pkg::EQ_ENTRIES-1:0][7:0] lane_level_equalizer_setting;
	logic [7:0] v, e;
	logic [7:0] pins_seen;
	logic [2:0] k;
	int compares = 0;
	int miscompares = 0;
	int cycles = 0;
	assign sda_in = !(sda_pull || (sda_oe && !sda_out));
	assign pins_seen = {5'h00, source_hotplug_out, source_adapter_detect_out, main_link_enable};
	rdr_register_bank #(.SLAVE_ADDR(DEV), .PART_IDENTITY(PART_ID)) u_rdr_register_bank (
		.clk_sys, .reset_n, .scl_in, .sda_in, .sda_out, .sda_oe, .sink_hotplug_in,
		.sink_adapter_detect_in, .squelch_open, .pre_emphasis_active, .source_hotplug_out,
		.source_adapter_detect_out, .main_link_enable, .emphasis_trim, .swing_trim,
		.tmds_swing_select, .tmds_emphasis_select, .lane_level_equalizer_setting);
	rdr_host_model #(.DEV_ADDR(DEV)) u_rdr_host_model (.clk_sys, .scl_drv(scl_in),
		.sda_pull, .sda_line(sda_in));
	task automatic end_sim();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
		logic [7:0] d;
		u_rdr_host_model.rd(ptr, d);
		check_val(d, exp);
	endtask
	task automatic cfg(input logic [7:0] up, input logic [7:0] mid, input logic [7:0] lo);
		u_rdr_host_model.wr(8'h1C, up);
		u_rdr_host_model.wr(8'h1D, mid);
		u_rdr_host_model.wr(8'h1E, lo);
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			end_sim();
		end
	end
	initial begin
		reset_n = 1'b0;
		sink_hotplug_in = 1'b0;
		sink_adapter_detect_in = 1'b0;
		squelch_open = 1'b0;
		pre_emphasis_active = 1'b0;
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
		check_val({6'h00, emphasis_trim}, 8'h01);
		check_val({5'h00, tmds_swing_select, tmds_emphasis_select}, 8'h00);
		rd_chk(8'h15, 8'h08);
		rd_chk(8'h17, 8'h00);
		rd_chk(8'h20, {PART_ID, 1'b0});
		rd_chk(8'h1B, 8'h00);
		for (int i = 0; i < 4; i++) begin
			k = 3'(i);
			v = {3'h0, k[1:0], k[1], k[1:0]};
			pre_emphasis_active <= k[0];
			u_rdr_host_model.wr(8'h15, v);
			check_val({6'h00, emphasis_trim}, {6'h00, v[4:3]});
			check_val({6'h00, swing_trim}, k[0] ? 8'h01 : {6'h00, v[4:3]});
			check_val({5'h00, tmds_swing_select, tmds_emphasis_select}, {5'h00, v[2:0]});
			rd_chk(8'h15, v);
		end
		// hot-plug test, polarity and adapter test in every mix; hot-plug, adapter detect and link enable pins all checked
		for (int j = 0; j < 8; j++) begin
			k = 3'(j);
			v = {4'h0, k[2], 1'b0, k[1:0]};
			sink_hotplug_in <= k[0];
			sink_adapter_detect_in <= k[1] ^ k[2];
			squelch_open <= ~k[1];
			u_rdr_host_model.wr(8'h17, v);
			e = {5'h00, k[2] | k[0], (k[0] | (k[1] ^ k[2])) ^ k[1], (k[2] | k[0]) & ~k[1]};
			check_val(pins_seen, e);
			rd_chk(8'h17, v);
		end
		cfg(8'h00, 8'h01, 8'h03);
		u_rdr_host_model.wr(8'h1F, 8'hDD);
		rd_chk(8'h1F, 8'h55);
		rd_chk(8'h1E, 8'h03);
		cfg(8'h00, 8'h02, 8'h06);
		u_rdr_host_model.wr(8'h1F, 8'hFF);
		check_val(lane_level_equalizer_setting[0], 8'h55);
		check_val(lane_level_equalizer_setting[7], 8'h77);
		cfg(8'hF0, 8'h02, 8'h06);
		rd_chk(8'h1F, 8'h77);
		rd_chk(8'h1C, 8'h00);
		cfg(8'h01, 8'h02, 8'h06);
		rd_chk(8'h1F, 8'h00);
		u_rdr_host_model.wr(8'h15, 8'h12);
		u_rdr_host_model.wr(8'h1B, 8'h00);
		rd_chk(8'h15, 8'h12);
		u_rdr_host_model.wr(8'h1B, 8'h40);
		check_val(lane_level_equalizer_setting[0], 8'h00);
		check_val(lane_level_equalizer_setting[7], 8'h00);
		rd_chk(8'h15, 8'h12);
		rd_chk(8'h1E, 8'h06);
		u_rdr_host_model.wr(8'h20, 8'h00);
		rd_chk(8'h20, {PART_ID, 1'b1});
		u_rdr_host_model.wr(8'h22, 8'hFF);
		u_rdr_host_model.wr(8'h27, 8'hA5);
		rd_chk(8'h22, rdr_pkg::RO_TEST_VALUE);
		rd_chk(8'h27, rdr_pkg::RO_TEST_VALUE);
		u_rdr_host_model.wr(8'h1B, 8'h80);
		rd_chk(8'h15, 8'h08);
		rd_chk(8'h20, {PART_ID, 1'b0});
		rd_chk(8'h1E, 8'h00);
		check_val(8'(u_rdr_host_model.nacks), 8'h00);
		end_sim();
	end
endmodule
